// [rtl/cal_scheduler.sv]
// chip calibration scheduler: fast clock, amplitude and comparator offset
// assumes converter, detector and sequencer strobes on hclk; slow_osc is a pin
//
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/1ps

module cal_scheduler (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        seq_trigger,
	input  wire logic        tof_active,
	input  wire logic        slow_osc,
	output logic             fast_osc_en,
	output logic             ring_cal_start,
	input  wire logic        ring_cal_done,
	output logic             tdc_start,
	output logic             tdc_stop,
	input  wire logic        tdc_done,
	input  wire logic [15:0] tdc_whole,
	input  wire logic [15:0] tdc_frac,
	input  wire logic        wave_pulse,
	output logic             peak_hold_en,
	output logic             discharge_en,
	output logic      [1:0]  ref_level,
	input  wire logic        discharge_done,
	output logic             comp_cal_start,
	input  wire logic        comp_cal_done,
	input  wire logic [7:0]  comp_cal_level,
	output logic      [7:0]  zero_cross_level
);

	typedef enum logic [3:0] {
		ST_IDLE,
		ST_RING_CAL,
		ST_FCAL_SYNC,
		ST_FCAL_RUN,
		ST_AMP_HOLD,
		ST_DISCH,
		ST_TDC_WAIT,
		ST_ZCC_RUN
	} state_t;

	typedef enum logic [2:0] {
		JOB_FCAL,
		JOB_AMP,
		JOB_CAL_HIGH,
		JOB_CAL_LOW,
		JOB_ZCC
	} job_t;

	state_t      state_reg;
	job_t        job_reg;
	job_t        pick_job;
	logic        pick_valid;
	logic [31:0] clock_power_config_reg;
	logic [31:0] frontend_rate_config_reg;
	logic [31:0] amplitude_meas_config_reg;
	logic [31:0] fast_clock_cal_value_reg;
	logic [31:0] amplitude_up_result_reg;
	logic [31:0] amplitude_down_result_reg;
	logic [31:0] amplitude_cal_high_result_reg;
	logic [31:0] amplitude_cal_low_result_reg;
	logic [7:0]  zero_cross_level_reg;
	logic        fast_clock_cal_updated_flag_reg;
	logic        fcal_pend_reg;
	logic        amp_pend_reg;
	logic        amc_pend_reg;
	logic        zcc_pend_reg;
	logic        dir_up_reg;
	logic [4:0]  wave_cnt_reg;
	logic [1:0]  slow_cnt_reg;
	logic        slow_sync1_reg;
	logic        slow_sync2_reg;
	logic        slow_prev_reg;
	logic        slow_edge;
	logic        fcal_fire;
	logic        amp_fire;
	logic        amc_fire;
	logic        zcc_fire;
	logic        result_take;
	logic        amp_done;
	logic        start_job;
	logic [4:0]  peak_detect_end_wave;
	logic        wr_pend_reg;
	logic [9:0]  wr_idx_reg;
	logic        addr_ok;
	logic        addr_mapped;
	logic [9:0]  rd_idx;
	logic [31:0] rd_data;
	logic        rd_cal_value;

	assign peak_detect_end_wave =
		amplitude_meas_config_reg[cal_sched_pkg::PD_END_LSB +: cal_sched_pkg::PD_END_W];
	assign zero_cross_level = zero_cross_level_reg;

	// slow oscillator pin: two-stage synchroniser, edge taken after the second stage
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			slow_sync1_reg <= 1'b0;
			slow_sync2_reg <= 1'b0;
			slow_prev_reg  <= 1'b0;
		end else begin
			slow_sync1_reg <= slow_osc;
			slow_sync2_reg <= slow_sync1_reg;
			slow_prev_reg  <= slow_sync2_reg;
		end
	end

	assign slow_edge = slow_sync2_reg & ~slow_prev_reg;

	// rate counters
	rate_counter u_fcal_rate (
		.hclk        (hclk),
		.hresetn     (hresetn),
		.event_pulse (seq_trigger),
		.rate_code   (clock_power_config_reg[cal_sched_pkg::FCI_LSB +: cal_sched_pkg::RATE_W]),
		.fire        (fcal_fire)
	);

	rate_counter u_amp_rate (
		.hclk        (hclk),
		.hresetn     (hresetn),
		.event_pulse (seq_trigger),
		.rate_code   (amplitude_meas_config_reg[cal_sched_pkg::AMPLITUDE_MEAS_RATE_LSB +: cal_sched_pkg::RATE_W]),
		.fire        (amp_fire)
	);

	rate_counter u_amplitude_cal_rate (
		.hclk        (hclk),
		.hresetn     (hresetn),
		.event_pulse (amp_done),
		.rate_code   (amplitude_meas_config_reg[cal_sched_pkg::AMPLITUDE_CAL_RATE_LSB +: cal_sched_pkg::RATE_W]),
		.fire        (amc_fire)
	);

	rate_counter u_zcc_rate (
		.hclk        (hclk),
		.hresetn     (hresetn),
		.event_pulse (seq_trigger),
		.rate_code   (frontend_rate_config_reg[cal_sched_pkg::ZCC_RATE_LSB +: cal_sched_pkg::RATE_W]),
		.fire        (zcc_fire)
	);

	// task choice: comparator, fast clock, amplitude, amplitude calibration
	always_comb begin
		pick_valid = 1'b1;
		pick_job   = JOB_ZCC;
		if (zcc_pend_reg) begin
			pick_job = JOB_ZCC;
		end else if (fcal_pend_reg) begin
			pick_job = JOB_FCAL;
		end else if (amp_pend_reg) begin
			pick_job = JOB_AMP;
		end else if (amc_pend_reg) begin
			pick_job = JOB_CAL_HIGH;
		end else begin
			pick_valid = 1'b0;
		end
	end

	assign start_job   = (state_reg == ST_IDLE) && pick_valid;
	assign result_take = (state_reg == ST_TDC_WAIT) && tdc_done;
	assign amp_done    = result_take && (job_reg == JOB_AMP);

	// pending requests; a new fire wins over the take in the same cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fcal_pend_reg <= 1'b0;
			amp_pend_reg  <= 1'b0;
			amc_pend_reg  <= 1'b0;
			zcc_pend_reg  <= 1'b1;
		end else begin
			fcal_pend_reg <= fcal_fire | (fcal_pend_reg & ~(start_job && pick_job == JOB_FCAL));
			amp_pend_reg  <= (amp_fire && peak_detect_end_wave != 5'h00)
				| (amp_pend_reg & ~(start_job && pick_job == JOB_AMP));
			amc_pend_reg  <= amc_fire
				| (amc_pend_reg & ~(start_job && pick_job == JOB_CAL_HIGH));
			zcc_pend_reg  <= zcc_fire | (zcc_pend_reg & ~(start_job && pick_job == JOB_ZCC));
		end
	end

	// sequencer and analog strobes
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg      <= ST_IDLE;
			job_reg        <= JOB_ZCC;
			ring_cal_start <= 1'b0;
			tdc_start      <= 1'b0;
			tdc_stop       <= 1'b0;
			comp_cal_start <= 1'b0;
			peak_hold_en   <= 1'b0;
			discharge_en   <= 1'b0;
			ref_level      <= cal_sched_pkg::REF_PEAK;
			wave_cnt_reg   <= 5'h00;
			slow_cnt_reg   <= 2'h0;
		end else begin
			ring_cal_start <= 1'b0;
			tdc_start      <= 1'b0;
			tdc_stop       <= 1'b0;
			comp_cal_start <= 1'b0;
			case (state_reg)
				ST_IDLE: begin
					if (pick_valid) begin
						job_reg <= pick_job;
						if (pick_job == JOB_ZCC) begin
							state_reg      <= ST_ZCC_RUN;
							comp_cal_start <= 1'b1;
						end else begin
							state_reg      <= ST_RING_CAL;
							ring_cal_start <= 1'b1;
						end
					end
				end
				ST_RING_CAL: begin
					if (ring_cal_done) begin
						case (job_reg)
							JOB_FCAL: begin
								state_reg <= ST_FCAL_SYNC;
							end
							JOB_AMP: begin
								state_reg    <= ST_AMP_HOLD;
								wave_cnt_reg <= 5'h00;
							end
							default: begin
								state_reg    <= ST_DISCH;
								discharge_en <= 1'b1;
								tdc_start    <= 1'b1;
								ref_level    <= (job_reg == JOB_CAL_LOW) ?
									cal_sched_pkg::REF_HALF : cal_sched_pkg::REF_FULL;
							end
						endcase
					end
				end
				ST_FCAL_SYNC: begin
					if (slow_edge) begin
						state_reg    <= ST_FCAL_RUN;
						slow_cnt_reg <= 2'h0;
						tdc_start    <= 1'b1;
					end
				end
				ST_FCAL_RUN: begin
					if (slow_edge) begin
						if (slow_cnt_reg == cal_sched_pkg::FCAL_SPAN_LAST) begin
							state_reg <= ST_TDC_WAIT;
							tdc_stop  <= 1'b1;
						end else begin
							slow_cnt_reg <= slow_cnt_reg + 2'h1;
						end
					end
				end
				ST_AMP_HOLD: begin
					if (wave_pulse) begin
						if (wave_cnt_reg == 5'h00) begin
							peak_hold_en <= 1'b1;
						end
						if (wave_cnt_reg == peak_detect_end_wave) begin
							peak_hold_en <= 1'b0;
							state_reg    <= ST_DISCH;
							discharge_en <= 1'b1;
							tdc_start    <= 1'b1;
							ref_level    <= cal_sched_pkg::REF_PEAK;
						end else begin
							wave_cnt_reg <= wave_cnt_reg + 5'h01;
						end
					end
				end
				ST_DISCH: begin
					if (discharge_done) begin
						discharge_en <= 1'b0;
						tdc_stop     <= 1'b1;
						state_reg    <= ST_TDC_WAIT;
					end
				end
				ST_TDC_WAIT: begin
					if (tdc_done) begin
						if (job_reg == JOB_CAL_HIGH) begin
							job_reg        <= JOB_CAL_LOW;
							state_reg      <= ST_RING_CAL;
							ring_cal_start <= 1'b1;
						end else begin
							state_reg <= ST_IDLE;
						end
					end
				end
				ST_ZCC_RUN: begin
					if (comp_cal_done) begin
						state_reg <= ST_IDLE;
					end
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// fast oscillator only for converter work or a flight measurement
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fast_osc_en <= 1'b0;
		end else begin
			fast_osc_en <= tof_active || (state_reg != ST_IDLE && state_reg != ST_ZCC_RUN)
				|| (start_job && pick_job != JOB_ZCC);
		end
	end

	// raw converter results, whole periods above fraction
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fast_clock_cal_value_reg      <= cal_sched_pkg::RESULT_RESET;
			amplitude_up_result_reg       <= cal_sched_pkg::RESULT_RESET;
			amplitude_down_result_reg     <= cal_sched_pkg::RESULT_RESET;
			amplitude_cal_high_result_reg <= cal_sched_pkg::RESULT_RESET;
			amplitude_cal_low_result_reg  <= cal_sched_pkg::RESULT_RESET;
			dir_up_reg                    <= 1'b1;
		end else if (result_take) begin
			case (job_reg)
				JOB_FCAL: begin
					fast_clock_cal_value_reg <= {tdc_whole, tdc_frac};
				end
				JOB_AMP: begin
					dir_up_reg <= ~dir_up_reg;
					if (dir_up_reg) begin
						amplitude_up_result_reg <= {tdc_whole, tdc_frac};
					end else begin
						amplitude_down_result_reg <= {tdc_whole, tdc_frac};
					end
				end
				JOB_CAL_HIGH: begin
					amplitude_cal_high_result_reg <= {tdc_whole, tdc_frac};
				end
				JOB_CAL_LOW: begin
					amplitude_cal_low_result_reg <= {tdc_whole, tdc_frac};
				end
				default: begin
					dir_up_reg <= dir_up_reg;
				end
			endcase
		end
	end

	// update flag: new result sets it, reading the value clears it, set wins
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fast_clock_cal_updated_flag_reg <= 1'b0;
		end else begin
			fast_clock_cal_updated_flag_reg <= (result_take && job_reg == JOB_FCAL)
				| (fast_clock_cal_updated_flag_reg & ~rd_cal_value);
		end
	end

	// bus slave: zero wait states, writes land in the data phase
	assign addr_ok      = hsel && hready && htrans[1];
	assign addr_mapped  = (haddr[31:12] == 20'h00000) && (haddr[1:0] == 2'h0);
	assign rd_idx       = haddr[11:2];
	assign rd_cal_value = addr_ok && !hwrite && addr_mapped
		&& rd_idx == cal_sched_pkg::IDX_FAST_CLOCK_CAL_VALUE;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
			wr_idx_reg  <= 10'h000;
			hreadyout   <= 1'b0;
			hresp       <= 1'b0;
		end else begin
			hreadyout   <= 1'b1;
			hresp       <= 1'b0;
			wr_pend_reg <= addr_ok && hwrite && addr_mapped;
			wr_idx_reg  <= rd_idx;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			clock_power_config_reg    <= cal_sched_pkg::CONFIG_RESET;
			frontend_rate_config_reg  <= cal_sched_pkg::CONFIG_RESET;
			amplitude_meas_config_reg <= cal_sched_pkg::CONFIG_RESET;
		end else if (wr_pend_reg) begin
			case (wr_idx_reg)
				cal_sched_pkg::IDX_CLOCK_POWER_CONFIG:    clock_power_config_reg    <= hwdata;
				cal_sched_pkg::IDX_FRONTEND_RATE_CONFIG:  frontend_rate_config_reg  <= hwdata;
				cal_sched_pkg::IDX_AMPLITUDE_MEAS_CONFIG: amplitude_meas_config_reg <= hwdata;
				default: clock_power_config_reg <= clock_power_config_reg;
			endcase
		end
	end

	// calibration result overrides a user write in the same cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			zero_cross_level_reg <= cal_sched_pkg::ZCL_RESET;
		end else if (state_reg == ST_ZCC_RUN && comp_cal_done) begin
			zero_cross_level_reg <= comp_cal_level;
		end else if (wr_pend_reg && wr_idx_reg == cal_sched_pkg::IDX_ZERO_CROSS_LEVEL) begin
			zero_cross_level_reg <= hwdata[cal_sched_pkg::ZCL_W-1:0];
		end
	end

	always_comb begin
		rd_data = 32'h0000_0000;
		case (rd_idx)
			cal_sched_pkg::IDX_CLOCK_POWER_CONFIG:    rd_data = clock_power_config_reg;
			cal_sched_pkg::IDX_FRONTEND_RATE_CONFIG:  rd_data = frontend_rate_config_reg;
			cal_sched_pkg::IDX_AMPLITUDE_MEAS_CONFIG: rd_data = amplitude_meas_config_reg;
			cal_sched_pkg::IDX_ZERO_CROSS_LEVEL:      rd_data = {24'h000000, zero_cross_level_reg};
			cal_sched_pkg::IDX_FAST_CLOCK_CAL_VALUE:  rd_data = fast_clock_cal_value_reg;
			cal_sched_pkg::IDX_AMPLITUDE_UP:          rd_data = amplitude_up_result_reg;
			cal_sched_pkg::IDX_AMPLITUDE_DOWN:        rd_data = amplitude_down_result_reg;
			cal_sched_pkg::IDX_AMPLITUDE_CAL_HIGH:    rd_data = amplitude_cal_high_result_reg;
			cal_sched_pkg::IDX_AMPLITUDE_CAL_LOW:     rd_data = amplitude_cal_low_result_reg;
			cal_sched_pkg::IDX_CAL_STATUS: begin
				rd_data[cal_sched_pkg::STAT_UPD_BIT]  = fast_clock_cal_updated_flag_reg;
				rd_data[cal_sched_pkg::STAT_BUSY_BIT] = (state_reg != ST_IDLE);
			end
			default: rd_data = 32'h0000_0000;
		endcase
		// read right behind a write to the same word sees the new data
		if (wr_pend_reg && wr_idx_reg == rd_idx) begin
			if (rd_idx == cal_sched_pkg::IDX_ZERO_CROSS_LEVEL) begin
				rd_data = {24'h000000, hwdata[cal_sched_pkg::ZCL_W-1:0]};
			end else if (rd_idx == cal_sched_pkg::IDX_CLOCK_POWER_CONFIG
				|| rd_idx == cal_sched_pkg::IDX_FRONTEND_RATE_CONFIG
				|| rd_idx == cal_sched_pkg::IDX_AMPLITUDE_MEAS_CONFIG) begin
				rd_data = hwdata;
			end
		end
		if (!addr_mapped) begin
			rd_data = 32'h0000_0000;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (addr_ok && !hwrite) begin
			hrdata <= rd_data;
		end
	end

endmodule

// [rtl/cal_sched_pkg.sv]
// constants, field layout and rate decoding of the calibration scheduler
// assumes AHB-Lite word access, registers indexed by haddr[11:2]
//
// Overview of operation
// - fast clock calibration times four slow oscillator periods with the converter
// - interval field picks sequence triggers between fast clock calibrations, 0 is off
// - calibration result kept raw in the fast clock value word at index 0x0E4
// - raw results are 32 bits: upper half whole periods, lower half fraction
// - ring oscillator is calibrated at the start of every converter measurement
// - fast oscillator runs only while a converter or flight measurement needs it
// - amplitude: hold peak first to end wave, discharge and time it
// - amplitude calibration measures discharge at full and at half reference
// - amplitude rate field counts sequence cycles per measurement, 0 is off
// - peak end field gives stop wave 1..31, zero disables amplitude measurement
// - calibration rate field counts amplitude measurements per calibration, 0 is off
// - results stored at 0x082 up, 0x083 high, 0x086 down, 0x087 low
// - peak holding always starts at the first detected wave
// - comparator offset calibration runs once after reset, then at its rate
// - comparator calibration rate field lives in the register at 0x0C9
// - each comparator calibration rewrites the zero-cross level register
// - zero-cross level accepts writes; next comparator calibration overwrites them
// - update flag reads 1 after a new calibration value, 0 otherwise

package cal_sched_pkg;

	localparam logic [9:0] IDX_CLOCK_POWER_CONFIG   = 10'h0C5;
	localparam logic [9:0] IDX_FRONTEND_RATE_CONFIG = 10'h0C9;
	localparam logic [9:0] IDX_AMPLITUDE_MEAS_CONFIG = 10'h0CB;
	localparam logic [9:0] IDX_ZERO_CROSS_LEVEL     = 10'h0D0;
	localparam logic [9:0] IDX_CAL_STATUS           = 10'h0D1;
	localparam logic [9:0] IDX_FAST_CLOCK_CAL_VALUE = 10'h0E4;
	localparam logic [9:0] IDX_AMPLITUDE_UP         = 10'h082;
	localparam logic [9:0] IDX_AMPLITUDE_CAL_HIGH   = 10'h083;
	localparam logic [9:0] IDX_AMPLITUDE_DOWN       = 10'h086;
	localparam logic [9:0] IDX_AMPLITUDE_CAL_LOW    = 10'h087;

	localparam int RATE_W          = 3;
	localparam int FCI_LSB         = 0;
	localparam int ZCC_RATE_LSB    = 0;
	localparam int AMPLITUDE_MEAS_RATE_LSB     = 0;
	localparam int PD_END_LSB      = 3;
	localparam int PD_END_W        = 5;
	localparam int AMPLITUDE_CAL_RATE_LSB    = 8;
	localparam int STAT_UPD_BIT    = 0;
	localparam int STAT_BUSY_BIT   = 1;
	localparam int ZCL_W           = 8;
	localparam int RATE_CNT_W      = 7;

	localparam logic [31:0] CONFIG_RESET   = 32'h0000_0000;
	localparam logic [31:0] RESULT_RESET   = 32'h0000_0000;
	localparam logic [7:0]  ZCL_RESET      = 8'h00;
	localparam logic [1:0]  FCAL_SPAN_LAST = 2'h3;

	localparam logic [1:0] REF_PEAK = 2'h0;
	localparam logic [1:0] REF_FULL = 2'h1;
	localparam logic [1:0] REF_HALF = 2'h2;

	// rate code to event count: 0 off, then 1 2 5 10 20 50 100
	function automatic logic [RATE_CNT_W-1:0] rate_limit(input logic [RATE_W-1:0] code);
		case (code)
			3'h0:    rate_limit = 7'h00;
			3'h1:    rate_limit = 7'h01;
			3'h2:    rate_limit = 7'h02;
			3'h3:    rate_limit = 7'h05;
			3'h4:    rate_limit = 7'h0A;
			3'h5:    rate_limit = 7'h14;
			3'h6:    rate_limit = 7'h32;
			default: rate_limit = 7'h64;
		endcase
	endfunction

endpackage

// [rtl/rate_counter.sv]
// event counter that fires once every selected number of events
// assumes event_pulse and rate_code on hclk
`timescale 1ns/1ps

module rate_counter (
	input  wire logic                              hclk,
	input  wire logic                              hresetn,
	input  wire logic                              event_pulse,
	input  wire logic [cal_sched_pkg::RATE_W-1:0]  rate_code,
	output logic                                   fire
);

	logic [cal_sched_pkg::RATE_CNT_W-1:0] count_reg;
	logic [cal_sched_pkg::RATE_CNT_W-1:0] limit;
	logic [cal_sched_pkg::RATE_CNT_W-1:0] count_next;

	assign limit      = cal_sched_pkg::rate_limit(rate_code);
	assign count_next = count_reg + 7'h01;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			count_reg <= 7'h00;
			fire      <= 1'b0;
		end else begin
			fire <= 1'b0;
			if (event_pulse) begin
				if (limit == 7'h00) begin
					count_reg <= 7'h00;
				end else if (count_next >= limit) begin
					count_reg <= 7'h00;
					fire      <= 1'b1;
				end else begin
					count_reg <= count_next;
				end
			end
		end
	end

endmodule

// [verif/cal_scheduler_asserts.sv]
// checker on the calibration scheduler ports
// assumes one hclk domain; bound onto every cal_scheduler
`timescale 1ns/1ps
module cal_scheduler_chk (
	input wire logic       hclk,
	input wire logic       hresetn,
	input wire logic       hreadyout,
	input wire logic       hresp,
	input wire logic       fast_osc_en,
	input wire logic       ring_cal_start,
	input wire logic       tdc_start,
	input wire logic       wave_pulse,
	input wire logic       peak_hold_en,
	input wire logic       discharge_en,
	input wire logic [1:0] ref_level,
	input wire logic       discharge_done,
	input wire logic       comp_cal_start,
	input wire logic       comp_cal_done,
	input wire logic [7:0] comp_cal_level,
	input wire logic [7:0] zero_cross_level
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence s_out_of_reset;
		$rose(hreadyout);
	endsequence
	sequence s_discharge_end;
		$fell(discharge_en);
	endsequence
	property p_bus_okay;
		$past(hresetn) |-> hreadyout && !hresp;
	endproperty
	property p_osc_tdc;
		tdc_start |-> fast_osc_en;
	endproperty
	property p_osc_ring;
		ring_cal_start |-> fast_osc_en;
	endproperty
	property p_first_cal;
		s_out_of_reset |-> ##[0:2] comp_cal_start;
	endproperty
	property p_cal_strobe;
		comp_cal_start |=> !comp_cal_start;
	endproperty
	property p_zcl_update;
		comp_cal_done |=> zero_cross_level == $past(comp_cal_level);
	endproperty
	property p_peak_start;
		$rose(peak_hold_en) |-> $past(wave_pulse);
	endproperty
	property p_discharge_end;
		s_discharge_end |-> $past(discharge_done);
	endproperty
	property p_hold_then_discharge;
		$rose(discharge_en) |-> !peak_hold_en;
	endproperty
	property p_ref_legal;
		ref_level != 2'h3;
	endproperty
	a_bus_okay: assert property (p_bus_okay) else $error("bus not ready or not okay");
	a_osc_tdc: assert property (p_osc_tdc) else $error("converter started without osc");
	a_osc_ring: assert property (p_osc_ring) else $error("ring cal without osc");
	a_first_cal: assert property (p_first_cal) else $error("no offset cal after reset");
	a_cal_strobe: assert property (p_cal_strobe) else $error("offset cal strobe too long");
	a_zcl_update: assert property (p_zcl_update) else $error("level not rewritten");
	a_peak_start: assert property (p_peak_start) else $error("hold not on wave");
	a_discharge_end: assert property (p_discharge_end) else $error("early discharge end");
	a_hold_then_discharge: assert property (p_hold_then_discharge)
		else $error("discharge during hold");
	a_ref_legal: assert property (p_ref_legal) else $error("bad reference level");
endmodule

bind cal_scheduler cal_scheduler_chk cal_scheduler_chk_i (
	.hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
	.fast_osc_en(fast_osc_en), .ring_cal_start(ring_cal_start), .tdc_start(tdc_start),
	.wave_pulse(wave_pulse), .peak_hold_en(peak_hold_en), .discharge_en(discharge_en),
	.ref_level(ref_level), .discharge_done(discharge_done), .comp_cal_start(comp_cal_start),
	.comp_cal_done(comp_cal_done), .comp_cal_level(comp_cal_level),
	.zero_cross_level(zero_cross_level)
);

// [verif/cal_scheduler_tb.sv]
// self-checking bench of the calibration scheduler
// assumes the bound checker; bench is bus master, converter and detectors
`timescale 1ns/1ps
module cal_scheduler_tb;
	logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, lf = 32'h9DE4;
	logic [1:0]  htrans = 2'h0, ref_level, td_sh = 2'h0;
	logic [2:0]  hsize = 3'h2, rc_sh = 3'h0, cc_sh = 3'h0;
	logic [15:0] tdc_whole = 16'h0, tdc_frac = 16'h0;
	logic [7:0]  comp_cal_level = 8'h0, zero_cross_level, zexp = 8'h0;
	logic        hready, hreadyout, hresp, fast_osc_en, ring_cal_start, tdc_start, tdc_stop;
	logic        peak_hold_en, discharge_en, comp_cal_start, win = 1'b0, de_q = 1'b0;
	logic        seq_trigger = 1'b0, tof_active = 1'b0, slow_osc = 1'b0, wave_pulse = 1'b0;
	logic        ring_cal_done = 1'b0, tdc_done = 1'b0, discharge_done = 1'b0;
	logic        comp_cal_done = 1'b0;
	logic [31:0] vals[$];
	logic [1:0]  refs[$];
	int          num_errors = 0, checks_done = 0, cyc = 0, rises = 0, nwav = 0, dc_cnt = 0;
	int          ndone = 0, ncomp = 0, nring = 0, nstart = 0;
	assign hready = hreadyout;

	cal_scheduler cal_scheduler_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hwdata, .hready, .hrdata, .hreadyout, .hresp, .seq_trigger, .tof_active, .slow_osc,
		.fast_osc_en, .ring_cal_start, .ring_cal_done, .tdc_start, .tdc_stop, .tdc_done,
		.tdc_whole, .tdc_frac, .wave_pulse, .peak_hold_en, .discharge_en, .ref_level,
		.discharge_done, .comp_cal_start, .comp_cal_done, .comp_cal_level, .zero_cross_level);

	initial begin
		forever #4 hclk = ~hclk;
	end

	function automatic logic [31:0] nxt(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic int lim(input int c);
		int t[8] = '{0, 1, 2, 5, 10, 20, 50, 100};
		return t[c];
	endfunction

	// converter, detectors, offset comparator and slow crystal
	always @(posedge hclk) begin
		lf <= nxt(lf);
		cyc <= cyc + 1;
		wave_pulse <= (cyc % 4 == 0);
		rc_sh <= {rc_sh[1:0], ring_cal_start};
		ring_cal_done <= rc_sh[2];
		cc_sh <= {cc_sh[1:0], comp_cal_start};
		comp_cal_done <= cc_sh[2];
		comp_cal_level <= lf[7:0];
		td_sh <= {td_sh[0], tdc_stop};
		tdc_done <= td_sh[1];
		{tdc_whole, tdc_frac} <= lf;
		dc_cnt <= discharge_en ? dc_cnt + 1 : 0;
		discharge_done <= discharge_en && dc_cnt == 5;
		de_q <= discharge_en;
		if (discharge_en && !de_q) refs.push_back(ref_level);
		if (cc_sh[2]) begin
			zexp <= lf[7:0];
			ncomp <= ncomp + 1;
		end
		if (td_sh[1]) begin
			vals.push_back(lf);
			ndone <= ndone + 1;
		end
		if (ring_cal_start) nring <= nring + 1;
		if (wave_pulse && peak_hold_en) nwav <= nwav + 1;
		if (cyc % 10 == 0) begin
			slow_osc <= ~slow_osc;
			if (!slow_osc && win) rises <= rises + 1;
		end
		if (tdc_start) begin
			win <= 1'b1;
			rises <= 0;
			nstart <= nstart + 1;
		end
		if (tdc_stop) win <= 1'b0;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [9:0] i, input logic [31:0] wd,
		output logic [31:0] rd);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {20'h0, i, 2'h0};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic wr(input logic [9:0] i, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, i, d, x);
	endtask
	task automatic rchk(input logic [9:0] i, input logic [31:0] e);
		logic [31:0] d;
		bus(1'b0, i, 32'h0, d);
		chk(d, e);
	endtask
	task automatic trig;
		@(posedge hclk) seq_trigger <= 1'b1;
		@(posedge hclk) seq_trigger <= 1'b0;
	endtask
	task automatic waitn(ref int c, input int n);
		int k;
		for (k = 0; k < 3000 && c < n; k++) @(posedge hclk);
		chk(32'(c >= n), 32'h1);
	endtask
	task automatic complete_run;
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	initial begin
		#160000;
		num_errors++;
		complete_run;
	end

	initial begin
		logic [31:0] v;
		int          n, k;
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		waitn(ncomp, 1);
		rchk(cal_sched_pkg::IDX_ZERO_CROSS_LEVEL, {24'h0, zexp});
		rchk(10'h3FF, 32'h0);
		wr(cal_sched_pkg::IDX_FAST_CLOCK_CAL_VALUE, 32'hFFFF_FFFF);
		rchk(cal_sched_pkg::IDX_FAST_CLOCK_CAL_VALUE, cal_sched_pkg::RESULT_RESET);
		$display("end of power-on and map test");
		wr(cal_sched_pkg::IDX_CLOCK_POWER_CONFIG, 32'h2);
		trig;
		repeat (50) @(posedge hclk);
		chk(nring, 0);
		trig;
		waitn(ndone, 1);
		chk(rises, 4);
		rchk(cal_sched_pkg::IDX_CAL_STATUS, 32'h1);
		rchk(cal_sched_pkg::IDX_FAST_CLOCK_CAL_VALUE, vals[0]);
		rchk(cal_sched_pkg::IDX_CAL_STATUS, 32'h0);
		rchk(cal_sched_pkg::IDX_CLOCK_POWER_CONFIG, 32'h2);
		wr(cal_sched_pkg::IDX_CLOCK_POWER_CONFIG, 32'h0);
		chk(fast_osc_en, 1'b0);
		tof_active <= 1'b1;
		for (k = 0; k < 20 && fast_osc_en !== 1'b1; k++) @(posedge hclk);
		chk(fast_osc_en, 1'b1);
		tof_active <= 1'b0;
		for (k = 0; k < 20 && fast_osc_en !== 1'b0; k++) @(posedge hclk);
		chk(fast_osc_en, 1'b0);
		$display("end of fast clock test");
		n = nwav;
		wr(cal_sched_pkg::IDX_AMPLITUDE_MEAS_CONFIG, 32'h0000_01F9);
		trig;
		waitn(ndone, 4);
		chk(nwav - n, 31);
		chk({26'h0, refs[0], refs[1], refs[2]}, 32'h6);
		rchk(cal_sched_pkg::IDX_AMPLITUDE_UP, vals[1]);
		rchk(cal_sched_pkg::IDX_AMPLITUDE_CAL_HIGH, vals[2]);
		rchk(cal_sched_pkg::IDX_AMPLITUDE_CAL_LOW, vals[3]);
		trig;
		waitn(ndone, 7);
		rchk(cal_sched_pkg::IDX_AMPLITUDE_DOWN, vals[4]);
		wr(cal_sched_pkg::IDX_AMPLITUDE_MEAS_CONFIG, 32'h0000_0101);
		trig;
		repeat (300) @(posedge hclk);
		chk(ndone, 7);
		chk(nring, nstart);
		$display("end of amplitude test");
		v = {24'h0, lf[15:8]};
		wr(cal_sched_pkg::IDX_ZERO_CROSS_LEVEL, v);
		rchk(cal_sched_pkg::IDX_ZERO_CROSS_LEVEL, v);
		wr(cal_sched_pkg::IDX_FRONTEND_RATE_CONFIG, 32'h1);
		trig;
		waitn(ncomp, 2);
		rchk(cal_sched_pkg::IDX_ZERO_CROSS_LEVEL, {24'h0, zexp});
		for (int c = 2; c < 8; c++) begin
			wr(cal_sched_pkg::IDX_FRONTEND_RATE_CONFIG, 32'(c));
			n = ncomp;
			repeat (lim(c) - 1) trig;
			repeat (20) @(posedge hclk);
			chk(ncomp, n);
			trig;
			waitn(ncomp, n + 1);
		end
		wr(cal_sched_pkg::IDX_FRONTEND_RATE_CONFIG, 32'h0);
		$display("end of offset calibration test");
		complete_run;
	end
endmodule
